// ### logic/dmm_map.svh
`ifndef DMM_MAP_SVH
`define DMM_MAP_SVH
`define DMM_LOC_INDIRECT   6'h00
`define DMM_LOC_TIMER      6'h01
`define DMM_LOC_PCL        6'h02
`define DMM_LOC_STATUS     6'h03
`define DMM_LOC_FSP        6'h04
`define DMM_LOC_PORT       6'h06
`define DMM_LOC_PWR        6'h08
`define DMM_LOC_WAKE       6'h09
`define DMM_LOC_PCHB       6'h0a
`define DMM_LOC_PULLLO     6'h0b
`define DMM_LOC_PULLHI     6'h0c
`define DMM_LOC_IEN        6'h0e
`define DMM_LOC_IFLG       6'h0f
`define DMM_SFR_LAST       6'h0f
`define DMM_RAM_FIRST      6'h10
`define DMM_RAM_LAST       6'h2f
`define DMM_F_PORTDIR      4'h6
`define DMM_F_PRESC        4'ha
`define DMM_F_BROWNOUT     4'hc
`define DMM_F_PWRAUX       4'hf
`define DMM_S_TBLPTR       4'h7
`define DMM_S_TBLDATA      4'h8
`define DMM_S_OSC          4'hf
`define DMM_STATUS_RESET   8'h18
`define DMM_PCL_RESET      9'h000
`define DMM_STAT_TO        4
`define DMM_STAT_PD        3
`define DMM_ZERO_BYTE      8'h00
`define DMM_PC_ONE         9'h001
`define DMM_PWR_RESET      8'h88
`define DMM_WAKE_RESET     8'h3f
`define DMM_PULLLO_RESET   8'hff
`define DMM_PULLHI_RESET   8'h3f
`define DMM_DIR_RESET      8'hff
`define DMM_TIMER_MAX      8'hff
`define DMM_TIMER_ONE      8'h01
`endif

// ### logic/dmm_pkg.sv
package dmm_pkg;
  typedef enum logic [2:0] {
    DMM_SP_R = 3'b001,
    DMM_SP_F = 3'b010,
    DMM_SP_S = 3'b100
  } dmm_space_t;
  typedef struct packed {
    logic       valid;
    dmm_space_t space;
    logic       write;
    logic       direct;
    logic [5:0] opcode_loc;
    logic [7:0] wdata;
  } dmm_access_t;
  typedef enum logic [4:0] {
    DMM_PC_NEXT  = 5'b00001,
    DMM_PC_SJMP  = 5'b00010,
    DMM_PC_LJMP  = 5'b00100,
    DMM_PC_SCALL = 5'b01000,
    DMM_PC_LONG_CALL_OP = 5'b10000
  } dmm_pc_op_t;
  typedef struct packed {
    logic       step;
    dmm_pc_op_t op;
    logic [8:0] target;
  } dmm_pc_cmd_t;
  typedef struct packed {
    logic [2:0] spare;
    logic       timeout_flag_n;
    logic       powerdown_flag_n;
    logic       zero;
    logic       half_carry;
    logic       carry;
  } dmm_status_t;
endpackage

// ### logic/dmm_ram.sv
`timescale 1ns/1ns
`include "dmm_map.svh"
module dmm_ram #(
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata
);
  logic [7:0] mem_reg [DEPTH];
  initial begin
    if (DEPTH > (1 << AW)) $error("dmm_ram depth exceeds address space");
  end
  // Plain storage; general RAM has no reset value
  always_ff @(posedge clk) begin
    if (we) begin
      mem_reg[addr] <= wdata;
    end
  end
  assign rdata = mem_reg[addr];
endmodule // dmm_ram

// ### logic/dmm_pc.sv
`timescale 1ns/1ns
`include "dmm_map.svh"
module dmm_pc
  import dmm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  dmm_pkg::dmm_pc_cmd_t cmd,
  input  wire logic        pcl_we,
  input  wire logic [7:0]  pcl_wdata,
  input  wire logic        pch_buf0,
  output logic      [8:0]  pc,
  output logic             push,
  output logic      [8:0]  push_addr
);
  logic [8:0] pc_reg;
  logic [8:0] pc_next;
  logic [8:0] pc_inc;
  assign pc_inc = pc_reg + `DMM_PC_ONE;
  always_comb begin
    pc_next = pc_reg;
    if (cmd.step) begin
      case (cmd.op)
        DMM_PC_SJMP, DMM_PC_LJMP: pc_next = cmd.target;
        DMM_PC_SCALL: pc_next = {pch_buf0, cmd.target[7:0]};
        DMM_PC_LONG_CALL_OP: pc_next = cmd.target;
        default: pc_next = pcl_we ? {pch_buf0, pcl_wdata} : pc_inc;
      endcase
    end
  end
  // Bit 8 comes from the buffer, an instruction word or the carry of the increment
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pc_reg <= `DMM_PCL_RESET;
    end else begin
      pc_reg <= pc_next;
    end
  end
  assign pc = pc_reg;
  assign push = cmd.step &&
    (cmd.op == DMM_PC_SCALL || cmd.op == DMM_PC_LONG_CALL_OP);
  assign push_addr = pc_inc;
endmodule // dmm_pc

// ### logic/dmm_core.sv
`timescale 1ns/1ns
`include "dmm_map.svh"
module dmm_core
  import dmm_pkg::*;
#(
  parameter int RAM_DEPTH = 32
) (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  dmm_pkg::dmm_access_t acc,
  output logic      [7:0]    rdata,
  input  dmm_pkg::dmm_pc_cmd_t pc_cmd,
  output logic      [8:0]    pc,
  output logic               stack_push,
  output logic      [8:0]    stack_push_addr,
  input  wire logic          alu_flags_we,
  input  wire logic [2:0]    alu_flags,
  input  wire logic          sleep_op,
  input  wire logic          clrwdt_op,
  input  wire logic          wdt_timeout,
  input  wire logic [1:0]    timer_src_sel,
  input  wire logic          inst_clk_tick,
  input  wire logic          ext_timer_clock,
  input  wire logic          low_osc_clock,
  input  wire logic [5:0]    port_pins,
  output logic      [7:0]    port_data,
  output logic      [7:0]    port_direction_reg,
  output logic      [7:0]    power_control,
  output logic      [7:0]    pull_low_control,
  output logic      [7:0]    pull_high_control,
  output logic      [7:0]    interrupt_enable,
  output logic               timer_overflow
);
  initial begin
    if (RAM_DEPTH != 32) $error("dmm_core needs 32 RAM locations");
  end
  logic [7:0] fsp_reg;
  dmm_status_t status_reg;
  logic [7:0] port_reg, pwr_reg, wake_reg, pchb_reg, pl_reg, ph_reg;
  logic [7:0] ien_reg, iflg_reg, timer_reg;
  logic [7:0] fdir_reg, fpresc_reg, fbod_reg, fpaux_reg;
  logic [7:0] stp_reg, std_reg, sosc_reg;
  logic [1:0] bank_selector;
  logic [5:0] loc;
  logic [7:0] flat_addr;
  logic       r_acc, f_acc, s_acc, wr, is_sfr, is_ram;
  logic       ram_we;
  logic [7:0] ram_rdata;
  logic [2:0] ext_sync, lo_sync;
  logic       src_tick;

  assign bank_selector = fsp_reg[7:6];
  assign r_acc = acc.valid && acc.space == DMM_SP_R;
  assign f_acc = acc.valid && acc.space == DMM_SP_F;
  assign s_acc = acc.valid && acc.space == DMM_SP_S;
  assign wr = acc.write;
  // Indirect port swaps the opcode location for the pointer location
  assign loc = (acc.direct && acc.opcode_loc != `DMM_LOC_INDIRECT) ?
               acc.opcode_loc : fsp_reg[5:0];
  assign flat_addr = {bank_selector, loc};
  // Bank bits dropped below: every bank aliases to bank zero
  assign is_sfr = r_acc && loc <= `DMM_SFR_LAST;
  assign is_ram = r_acc && loc >= `DMM_RAM_FIRST
                  && loc <= `DMM_RAM_LAST;
  assign ram_we = is_ram && wr;

  dmm_ram #(.DEPTH(RAM_DEPTH), .AW(5)) u_ram (
    .clk   (clk),
    .we    (ram_we),
    .addr  (5'(loc - `DMM_RAM_FIRST)),
    .wdata (acc.wdata),
    .rdata (ram_rdata)
  );

  function automatic logic sfr_w(input logic [5:0] l);
    sfr_w = is_sfr && wr && loc == l;
  endfunction

  dmm_pc u_pc (
    .clk       (clk),
    .reset_n   (reset_n),
    .cmd       (pc_cmd),
    .pcl_we    (sfr_w(`DMM_LOC_PCL)),
    .pcl_wdata (acc.wdata),
    .pch_buf0  (pchb_reg[0]),
    .pc        (pc),
    .push      (stack_push),
    .push_addr (stack_push_addr)
  );

  // Register page storage
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fsp_reg  <= `DMM_ZERO_BYTE;
      port_reg <= `DMM_ZERO_BYTE;
      pwr_reg  <= `DMM_PWR_RESET;
      wake_reg <= `DMM_WAKE_RESET;
      pchb_reg <= `DMM_ZERO_BYTE;
      pl_reg   <= `DMM_PULLLO_RESET;
      ph_reg   <= `DMM_PULLHI_RESET;
      ien_reg  <= `DMM_ZERO_BYTE;
      iflg_reg <= `DMM_ZERO_BYTE;
    end else begin
      if (sfr_w(`DMM_LOC_FSP))    fsp_reg  <= acc.wdata;
      if (sfr_w(`DMM_LOC_PORT))   port_reg <= acc.wdata;
      if (sfr_w(`DMM_LOC_PWR))    pwr_reg  <= acc.wdata;
      if (sfr_w(`DMM_LOC_WAKE))   wake_reg <= acc.wdata;
      if (sfr_w(`DMM_LOC_PCHB))   pchb_reg <= acc.wdata;
      if (sfr_w(`DMM_LOC_PULLLO)) pl_reg   <= acc.wdata;
      if (sfr_w(`DMM_LOC_PULLHI)) ph_reg   <= acc.wdata;
      if (sfr_w(`DMM_LOC_IEN))    ien_reg  <= acc.wdata;
      // Overflow set wins over a software clear in the same cycle
      if (sfr_w(`DMM_LOC_IFLG))   iflg_reg <= acc.wdata;
      if (timer_overflow)         iflg_reg[0] <= 1'b1;
    end
  end

  // F and S pages: four-bit location, bank bits never looked at
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fdir_reg   <= `DMM_DIR_RESET;
      fpresc_reg <= `DMM_ZERO_BYTE;
      fbod_reg   <= `DMM_ZERO_BYTE;
      fpaux_reg  <= `DMM_ZERO_BYTE;
      stp_reg    <= `DMM_ZERO_BYTE;
      std_reg    <= `DMM_ZERO_BYTE;
      sosc_reg   <= `DMM_ZERO_BYTE;
    end else if (wr) begin
      if (f_acc && acc.opcode_loc[5:4] == 2'b00) begin
        case (acc.opcode_loc[3:0])
          `DMM_F_PORTDIR:  fdir_reg   <= acc.wdata;
          `DMM_F_PRESC:    fpresc_reg <= acc.wdata;
          `DMM_F_BROWNOUT: fbod_reg   <= acc.wdata;
          `DMM_F_PWRAUX:   fpaux_reg  <= acc.wdata;
          default: ;
        endcase
      end
      if (s_acc && acc.opcode_loc[5:4] == 2'b00) begin
        case (acc.opcode_loc[3:0])
          `DMM_S_TBLPTR:  stp_reg  <= acc.wdata;
          `DMM_S_TBLDATA: std_reg  <= acc.wdata;
          `DMM_S_OSC:     sosc_reg <= acc.wdata;
          default: ;
        endcase
      end
    end
  end

  // Status: instruction events outrank a software write of the flags
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      status_reg <= `DMM_STATUS_RESET;
    end else begin
      if (sfr_w(`DMM_LOC_STATUS)) status_reg <= acc.wdata;
      if (alu_flags_we) status_reg[2:0] <= alu_flags;
      if (clrwdt_op) begin
        status_reg.timeout_flag_n   <= 1'b1;
        status_reg.powerdown_flag_n <= 1'b1;
      end
      if (sleep_op) begin
        status_reg.timeout_flag_n   <= 1'b1;
        status_reg.powerdown_flag_n <= 1'b0;
      end
      if (wdt_timeout) status_reg.timeout_flag_n <= 1'b0;
    end
  end

  // External clocks synchronised; only the second and third stage feed edges
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ext_sync <= 3'b000;
      lo_sync  <= 3'b000;
    end else begin
      ext_sync <= {ext_sync[1:0], ext_timer_clock};
      lo_sync  <= {lo_sync[1:0], low_osc_clock};
    end
  end
  always_comb begin
    case (timer_src_sel)
      2'b01:   src_tick = ext_sync[1] & ~ext_sync[2];
      2'b10:   src_tick = lo_sync[1] & ~lo_sync[2];
      default: src_tick = inst_clk_tick;
    endcase
  end

  // Timer: a write wins over a count tick in the same cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      timer_reg <= `DMM_ZERO_BYTE;
    end else if (sfr_w(`DMM_LOC_TIMER)) begin
      timer_reg <= acc.wdata;
    end else if (src_tick) begin
      timer_reg <= timer_reg + `DMM_TIMER_ONE;
    end
  end
  assign timer_overflow = src_tick && !sfr_w(`DMM_LOC_TIMER)
                          && timer_reg == `DMM_TIMER_MAX;

  // Read mux
  always_comb begin
    rdata = `DMM_ZERO_BYTE;
    if (is_ram) begin
      rdata = ram_rdata;
    end else if (is_sfr) begin
      case (loc[5:0])
        `DMM_LOC_INDIRECT: rdata = `DMM_ZERO_BYTE;
        `DMM_LOC_TIMER:    rdata = timer_reg;
        `DMM_LOC_PCL:      rdata = pc[7:0];
        `DMM_LOC_STATUS:   rdata = status_reg;
        `DMM_LOC_FSP:      rdata = fsp_reg;
        `DMM_LOC_PORT:     rdata = {port_reg[7:6], port_pins};
        `DMM_LOC_PWR:      rdata = pwr_reg;
        `DMM_LOC_WAKE:     rdata = wake_reg;
        `DMM_LOC_PCHB:     rdata = pchb_reg;
        `DMM_LOC_PULLLO:   rdata = pl_reg;
        `DMM_LOC_PULLHI:   rdata = ph_reg;
        `DMM_LOC_IEN:      rdata = ien_reg;
        `DMM_LOC_IFLG:     rdata = iflg_reg;
        default:           rdata = `DMM_ZERO_BYTE;
      endcase
    end else if (f_acc && !wr && acc.opcode_loc[5:4] == 2'b00) begin
      case (acc.opcode_loc[3:0])
        `DMM_F_PORTDIR:  rdata = fdir_reg;
        `DMM_F_PRESC:    rdata = fpresc_reg;
        `DMM_F_BROWNOUT: rdata = fbod_reg;
        `DMM_F_PWRAUX:   rdata = fpaux_reg;
        default:         rdata = `DMM_ZERO_BYTE;
      endcase
    end else if (s_acc && !wr && acc.opcode_loc[5:4] == 2'b00) begin
      case (acc.opcode_loc[3:0])
        `DMM_S_TBLPTR:  rdata = stp_reg;
        `DMM_S_TBLDATA: rdata = std_reg;
        `DMM_S_OSC:     rdata = sosc_reg;
        default:        rdata = `DMM_ZERO_BYTE;
      endcase
    end
  end

  assign port_data          = port_reg;
  assign port_direction_reg = fdir_reg;
  assign power_control      = pwr_reg;
  assign pull_low_control   = pl_reg;
  assign pull_high_control  = ph_reg;
  assign interrupt_enable   = ien_reg;

  timer_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    sfr_w(`DMM_LOC_TIMER) |=> timer_reg == $past(acc.wdata))
    else $error("timer write not taken");
  sleep_flags_a: assert property (@(posedge clk) disable iff (!reset_n)
    sleep_op && !wdt_timeout |=> !status_reg.powerdown_flag_n
    && status_reg.timeout_flag_n)
    else $error("sleep flags wrong");
  wdt_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
    wdt_timeout |=> !status_reg.timeout_flag_n)
    else $error("timeout flag not cleared");
  ljump_a: assert property (@(posedge clk) disable iff (!reset_n)
    pc_cmd.step && pc_cmd.op == DMM_PC_LJMP
    |-> !stack_push ##1 pc == $past(pc_cmd.target))
    else $error("jump target wrong");
  scall_a: assert property (@(posedge clk) disable iff (!reset_n)
    pc_cmd.step && pc_cmd.op == DMM_PC_SCALL |-> stack_push
    ##1 pc == {$past(pchb_reg[0]), $past(pc_cmd.target[7:0])})
    else $error("short call wrong");
  long_call_op_a: assert property (@(posedge clk) disable iff (!reset_n)
    pc_cmd.step && pc_cmd.op == DMM_PC_LONG_CALL_OP
    |-> stack_push_addr == 9'(pc + 9'h001))
    else $error("call push address wrong");
  pc_step_a: assert property (@(posedge clk) disable iff (!reset_n)
    pc_cmd.step && pc_cmd.op == DMM_PC_NEXT && !sfr_w(`DMM_LOC_PCL)
    |=> pc == 9'($past(pc) + 9'h001))
    else $error("pc did not step");
  timer_read_a: assert property (@(posedge clk) disable iff (!reset_n)
    is_sfr && loc == `DMM_LOC_TIMER |-> rdata == timer_reg)
    else $error("timer read not live");
  unassigned_a: assert property (@(posedge clk) disable iff (!reset_n)
    is_sfr && (loc == 6'h05 || loc == 6'h07 || loc == 6'h0d)
    |-> rdata == 8'h00)
    else $error("unassigned read not zero");
  alias_a: assert property (@(posedge clk) disable iff (!reset_n)
    sfr_w(`DMM_LOC_FSP) && acc.direct ##1 r_acc && acc.direct && !wr
    && acc.opcode_loc == `DMM_LOC_FSP
    |-> rdata == $past(acc.wdata))
    else $error("pointer alias read wrong");
  call_c: cover property (@(posedge clk)
    pc_cmd.step && pc_cmd.op == DMM_PC_SCALL);
  indirect_c: cover property (@(posedge clk)
    r_acc && acc.direct && acc.opcode_loc == `DMM_LOC_INDIRECT && is_ram);
  ovf_c: cover property (@(posedge clk) timer_overflow);
  fpage_c: cover property (@(posedge clk) f_acc && wr);
endmodule // dmm_core

// ### bench/dmm_core_model.sv
`timescale 1ns/1ns
module dmm_core_model (
  input  wire logic            clk,
  input  wire logic [7:0]      rdata,
  input  wire logic            stack_push,
  input  wire logic [8:0]      stack_push_addr,
  output dmm_pkg::dmm_access_t acc,
  output dmm_pkg::dmm_pc_cmd_t pc_cmd
);
  import dmm_pkg::*;
  logic [7:0] rd;
  logic       psh;
  logic [8:0] pa;
  initial begin
    acc    = '0;
    pc_cmd = '0;
  end
  // One instruction per call, then an idle cycle; idle fields carry
  // the inverse of the last request so a stale value never looks valid
  task automatic drive(input dmm_access_t a, input dmm_pc_cmd_t p);
    acc    = a;
    pc_cmd = p;
    #6;
    rd  = rdata;
    psh = stack_push;
    pa  = stack_push_addr;
    @(posedge clk);
    #1;
    acc    = {1'b0, ~a[$bits(a)-2:0]};
    pc_cmd = {1'b0, ~p[$bits(p)-2:0]};
    @(posedge clk);
    #1;
  endtask
endmodule // dmm_core_model

// ### bench/data_memory_map_and_pc_tb.sv
`timescale 1ns/1ns
module data_memory_map_and_pc_tb;
  import dmm_pkg::*;
  logic        clk, reset_n, stack_push, timer_overflow;
  dmm_access_t acc;
  dmm_pc_cmd_t pc_cmd;
  logic [8:0]  pc, stack_push_addr;
  logic        alu_flags_we, sleep_op, clrwdt_op, wdt_timeout;
  logic [2:0]  alu_flags;
  logic [1:0]  timer_src_sel;
  logic        inst_clk_tick, ext_timer_clock, low_osc_clock;
  logic [5:0]  port_pins;
  logic [7:0]  rdata, port_data, port_direction_reg, power_control;
  logic [7:0]  pull_low_control, pull_high_control, interrupt_enable;
  int          num_errors;
  int          num_checks;
  logic [5:0]  sfr_locs [6] = '{6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0e};
  logic [8:0]  holes [7] = '{9'h045, 9'h047, 9'h04d, 9'h070, 9'h080,
                             9'h106, 9'h096};
  logic [8:0]  page_regs [7] = '{9'h086, 9'h08a, 9'h08c, 9'h08f,
                                 9'h107, 9'h108, 9'h10f};

  dmm_core #(.RAM_DEPTH(32)) dmm_core_inst (.clk, .reset_n, .acc, .rdata,
    .pc_cmd, .pc, .stack_push, .stack_push_addr, .alu_flags_we,
    .alu_flags, .sleep_op, .clrwdt_op, .wdt_timeout, .timer_src_sel,
    .inst_clk_tick, .ext_timer_clock, .low_osc_clock, .port_pins,
    .port_data, .port_direction_reg, .power_control, .pull_low_control,
    .pull_high_control, .interrupt_enable, .timer_overflow);
  dmm_core_model dmm_core_model_inst (.clk, .rdata, .stack_push,
    .stack_push_addr, .acc, .pc_cmd);

  function automatic logic [7:0] pat(input logic [5:0] l);
    return ~{2'b10, l};
  endfunction
  function automatic logic [7:0] pv(input logic [8:0] e);
    return pat(e[5:0]) ^ {5'b0, e[8:6]};
  endfunction
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rw(input dmm_space_t s, input logic w,
                    input logic [5:0] l, input logic [7:0] d);
    dmm_core_model_inst.drive('{1'b1, s, w, 1'b1, l, d}, '0);
  endtask
  task automatic rc(input dmm_space_t s, input logic [5:0] l,
                    input logic [7:0] e);
    rw(s, 1'b0, l, 8'h00);
    chk(dmm_core_model_inst.rd, e);
  endtask
  task automatic pulse(input int k);
    {wdt_timeout, sleep_op, clrwdt_op, alu_flags_we} = 4'b1000 >> k;
    @(posedge clk);
    #1;
    {wdt_timeout, sleep_op, clrwdt_op, alu_flags_we} = 4'b0000;
  endtask
  task automatic pcs(input dmm_pc_op_t op, input logic [8:0] t,
                     input logic [8:0] e_pc, input logic e_psh,
                     input logic [8:0] e_pa);
    dmm_core_model_inst.drive('0, '{1'b1, op, t});
    chk(pc, e_pc);
    chk(dmm_core_model_inst.psh, e_psh);
    if (e_psh)
      chk(dmm_core_model_inst.pa, e_pa);
  endtask
  // Both pins toggle, the low-oscillator pin twice as often as the external one, so only the selected source may count
  task automatic run_src(input logic [1:0] sel);
    timer_src_sel = sel;
    for (int i = 0; i < 12; i++) begin
      low_osc_clock = i[0];
      ext_timer_clock = i[1];
      repeat (3) @(posedge clk);
      #1;
    end
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic t_reset;
    chk(pc, 9'h000);
    chk(port_direction_reg, 8'hff);
    chk(power_control, 8'h88);
    chk(pull_low_control, 8'hff);
    chk(pull_high_control, 8'h3f);
    chk(interrupt_enable, 8'h00);
    rc(DMM_SP_R, 6'h02, 8'h00);
    rc(DMM_SP_R, 6'h09, 8'h3f);
  endtask
  task automatic t_status;
    rc(DMM_SP_R, 6'h03, 8'h18);
    pulse(1);
    rc(DMM_SP_R, 6'h03, 8'h10);
    pulse(0);
    rc(DMM_SP_R, 6'h03, 8'h00);
    pulse(2);
    rc(DMM_SP_R, 6'h03, 8'h18);
    alu_flags = 3'b101;
    pulse(3);
    rc(DMM_SP_R, 6'h03, 8'h1d);
    rw(DMM_SP_R, 1'b1, 6'h03, 8'hba);
    rc(DMM_SP_R, 6'h03, 8'hba);
  endtask
  task automatic t_bank;
    rw(DMM_SP_R, 1'b1, 6'h04, 8'h52);
    rw(DMM_SP_R, 1'b1, 6'h12, 8'ha5);
    rw(DMM_SP_R, 1'b1, 6'h04, 8'hc0);
    rc(DMM_SP_R, 6'h12, 8'ha5);
    rc(DMM_SP_R, 6'h04, 8'hc0);
    rc(DMM_SP_R, 6'h00, 8'h00);
    for (int i = 0; i < 6; i++) begin
      rw(DMM_SP_R, 1'b1, sfr_locs[i], pat(sfr_locs[i]));
      rc(DMM_SP_R, sfr_locs[i], pat(sfr_locs[i]));
    end
    chk(power_control, pat(6'h08));
    chk(pull_low_control, pat(6'h0b));
    chk(pull_high_control, pat(6'h0c));
    chk(interrupt_enable, pat(6'h0e));
    rw(DMM_SP_R, 1'b1, 6'h06, 8'h33);
    chk(port_data, 8'h33);
  endtask
  task automatic t_indirect;
    rw(DMM_SP_R, 1'b1, 6'h04, 8'h6f);
    rw(DMM_SP_R, 1'b1, 6'h00, 8'h3c);
    rc(DMM_SP_R, 6'h00, 8'h3c);
    rw(DMM_SP_R, 1'b1, 6'h04, 8'h0e);
    rc(DMM_SP_R, 6'h2f, 8'h3c);
    rc(DMM_SP_R, 6'h00, pat(6'h0e));
    rw(DMM_SP_R, 1'b1, 6'h04, 8'hb0);
    rw(DMM_SP_R, 1'b1, 6'h00, 8'h99);
    rc(DMM_SP_R, 6'h00, 8'h00);
  endtask
  task automatic t_holes;
    for (int i = 0; i < 7; i++) begin
      rw(dmm_space_t'(holes[i][8:6]), 1'b1, holes[i][5:0], 8'hff);
      rc(dmm_space_t'(holes[i][8:6]), holes[i][5:0], 8'h00);
    end
  endtask
  task automatic t_pages;
    rw(DMM_SP_R, 1'b1, 6'h04, 8'hc0);
    for (int i = 0; i < 7; i++)
      rw(dmm_space_t'(page_regs[i][8:6]), 1'b1, page_regs[i][5:0],
         pv(page_regs[i]));
    for (int i = 0; i < 7; i++)
      rc(dmm_space_t'(page_regs[i][8:6]), page_regs[i][5:0],
         pv(page_regs[i]));
    chk(port_direction_reg, pv(9'h086));
    chk(port_data, 8'h33);
    rc(DMM_SP_R, 6'h0c, pat(6'h0c));
    rc(DMM_SP_R, 6'h0f, 8'h00);
    rc(DMM_SP_F, 6'h0e, 8'h00);
  endtask
  task automatic t_timer;
    rw(DMM_SP_R, 1'b1, 6'h01, 8'h55);
    rc(DMM_SP_R, 6'h01, 8'h55);
    inst_clk_tick = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    inst_clk_tick = 1'b0;
    rc(DMM_SP_R, 6'h01, 8'h57);
    rw(DMM_SP_R, 1'b1, 6'h01, 8'hff);
    inst_clk_tick = 1'b1;
    #6;
    chk(timer_overflow, 1'b1);
    @(posedge clk);
    #1;
    inst_clk_tick = 1'b0;
    rc(DMM_SP_R, 6'h01, 8'h00);
    rc(DMM_SP_R, 6'h0f, 8'h01);
    rw(DMM_SP_R, 1'b1, 6'h01, 8'h10);
    run_src(2'b01);
    rc(DMM_SP_R, 6'h01, 8'h13);
    run_src(2'b10);
    rc(DMM_SP_R, 6'h01, 8'h19);
    run_src(2'b00);
    rc(DMM_SP_R, 6'h01, 8'h19);
  endtask
  task automatic t_pc;
    pcs(DMM_PC_NEXT, 9'h000, 9'h001, 1'b0, 9'h000);
    pcs(DMM_PC_NEXT, 9'h1ff, 9'h002, 1'b0, 9'h000);
    rw(DMM_SP_R, 1'b1, 6'h0a, 8'h01);
    pcs(DMM_PC_SCALL, 9'h034, 9'h134, 1'b1, 9'h003);
    rw(DMM_SP_R, 1'b1, 6'h0a, 8'hfe);
    pcs(DMM_PC_SCALL, 9'h1ff, 9'h0ff, 1'b1, 9'h135);
    pcs(DMM_PC_SJMP, 9'h1f0, 9'h1f0, 1'b0, 9'h000);
    pcs(DMM_PC_LJMP, 9'h0a5, 9'h0a5, 1'b0, 9'h000);
    pcs(DMM_PC_LONG_CALL_OP, 9'h1c3, 9'h1c3, 1'b1, 9'h0a6);
    rc(DMM_SP_R, 6'h02, 8'hc3);
    rw(DMM_SP_R, 1'b1, 6'h0a, 8'h01);
    dmm_core_model_inst.drive('{1'b1, DMM_SP_R, 1'b1, 1'b1, 6'h02, 8'h40},
                              '{1'b1, DMM_PC_NEXT, 9'h000});
    chk(pc, 9'h140);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // A full pass needs about 320 cycles; this allows far more
  initial begin
    #200000;
    num_errors++;
    summarize();
  end
  initial begin
    num_errors = 0;
    num_checks = 0;
    reset_n = 1'b0;
    {alu_flags_we, sleep_op, clrwdt_op, wdt_timeout} = 4'b0000;
    alu_flags = 3'b000;
    timer_src_sel = 2'b00;
    {inst_clk_tick, ext_timer_clock, low_osc_clock} = 3'b000;
    port_pins = 6'h15;
    repeat (5) @(posedge clk);
    #1;
    reset_n = 1'b1;
    t_reset();
    t_status();
    t_bank();
    t_indirect();
    t_holes();
    t_pages();
    t_timer();
    t_pc();
    summarize();
  end
endmodule // data_memory_map_and_pc_tb
